/* File: include/tfh_defs.vh */
// Register map, field positions and reset values of the fault handler
`ifndef TFH_DEFS_VH
`define TFH_DEFS_VH
// Word addresses of the global registers
`define TFH_ADDR_NS_CTRL 8'h00
`define TFH_ADDR_S_CTRL 8'h01
`define TFH_ADDR_GFAULT 8'h02
// Bank region: word address 001_bbb_rr
`define TFH_BANK_REGION 3'h1
`define TFH_SUB_CTRL 2'h0
`define TFH_SUB_STATUS 2'h1
`define TFH_SUB_RESUME 2'h2
`define TFH_SUB_ATTR 2'h3
// Global control fields
`define TFH_G_GSE 0
`define TFH_G_STALL_DISABLE 1
`define TFH_G_USF 2
`define TFH_G_SMCF 3
`define TFH_G_GFRE 4
`define TFH_NS_CTRL_RST 5'h00
`define TFH_S_CTRL_RST 2'h0
// Bank control fields
`define TFH_C_MODE 0
`define TFH_C_HUF 1
`define TFH_C_FRE 2
`define TFH_C_SEC 3
`define TFH_CTRL_RST 4'h0
// Fault status fields
`define TFH_F_FAULT 0
`define TFH_F_MULTI 1
`define TFH_F_SS 2
`define TFH_FSR_RST 3'h0
// Resume field
`define TFH_R_TERM 0
// Global fault status fields
`define TFH_GF_ICF 0
`define TFH_GF_USF 1
`define TFH_GF_SMCF 2
`define TFH_GF_UCBF 3
`define TFH_GF_UICF 4
`define TFH_GF_CAF 5
`define TFH_GF_RST 6'h00
// Bank attribute fields
`define TFH_A_TYPE 1:0
`define TFH_A_WIDE 2
`define TFH_A_S2 6:3
`define TFH_A_IRQ 10:7
`define TFH_ATTR_RST 12'h000
// Context types
`define TFH_T_S2ONLY 2'h0
`define TFH_T_S1BYP 2'h1
`define TFH_T_S1FLT 2'h2
`define TFH_T_NESTED 2'h3
// Response codes
`define TFH_RSP_OKAY 2'h0
`define TFH_RSP_ABORT_REP 2'h1
`define TFH_RSP_ABORT_SIL 2'h2
`endif

/* File: verilog/tfh_attr_mem.v */
// Bank attribute store with one write port and two registered read ports
`timescale 1ns/1ns
module tfh_attr_mem #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk, // System clock
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write index
  input wire [WIDTH-1:0] wr_data, // Write word
  input wire [AW-1:0] rda_addr, // Read index, port a
  output reg [WIDTH-1:0] rda_data, // Registered word, port a
  input wire [AW-1:0] rdb_addr, // Read index, port b
  output reg [WIDTH-1:0] rdb_data // Registered word, port b
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Storage and registered reads; contents undefined until written
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rda_data <= mem[rda_addr];
    rdb_data <= mem[rdb_addr];
  end
endmodule // tfh_attr_mem

/* File: verilog/tfh_fault_handler.v */
// Translation fault handler: request buffer, fault records and registers
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "tfh_defs.vh"
module tfh_fault_handler #(
  parameter NB = 8, // Implemented banks, 1 to 8
  parameter NUM_IRQ = 8, // Implemented context interrupts
  parameter GSTALL_IMPL = 1, // Global stall supported
  parameter NS_STALL_DISABLE_SEC = 0, // Non-secure stall disable also forces secure terminate
  parameter NS_GSE_SEC = 0, // Non-secure global stall also governs secure banks
  parameter [3:0] TYPE_OK = 4'hF // Supported context types, one bit per type
) (
  input wire sys_clk, // Clock, 125 MHz
  input wire rst_b, // Asynchronous reset
  input wire [7:0] avs_address, // Word address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  output wire [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Slave not ready
  input wire req_valid, // Transaction waiting
  output wire req_ready, // Transaction retired
  input wire [3:0] req_bank, // Initial context bank
  input wire req_stream_miss, // No stream match
  input wire req_stream_multi, // Several stream matches
  input wire req_map_fault, // Map entry selects fault context
  output wire xlat_valid, // Translation request
  output reg [2:0] xlat_s1_bank, // First bank to use
  output reg [2:0] xlat_s2_bank, // Stage 2 bank when nested
  output reg xlat_nested, // Two-stage translation
  input wire xlat_done, // Translation finished
  input wire xlat_fault, // Translation failed
  input wire xlat_fault_s2, // Failure lies in stage 2 bank
  output wire rsp_valid, // Response pulse
  output reg [1:0] rsp_code // Response kind
);
  localparam S_START = 3'h0;
  localparam S_CHK1 = 3'h1;
  localparam S_CHK2 = 3'h2;
  localparam S_XLAT = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_RESP = 3'h5;
  localparam A_PASS = 2'h0;
  localparam A_ABORT = 2'h1;
  localparam A_WAIT = 2'h2;

  reg [3:0] ctl_reg [0:7];
  reg [2:0] fsr_reg [0:7];
  reg [4:0] nsc_reg;
  reg [1:0] sc_reg;
  reg [5:0] gfs_reg;
  reg ack_reg;
  reg [31:0] rd_reg;
  reg rd_mem_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [11:0] attr1_reg;
  reg [11:0] attr2_reg;
  reg [2:0] wait_bank_reg;
  reg wait_term_reg;
  reg [1:0] code_next;
  reg [5:0] gf_set;
  reg fsr_set_en;
  reg [2:0] fsr_set_bank;
  reg [2:0] fsr_set_val;
  reg [1:0] act;
  reg [2:0] fb;
  reg gstall;
  reg any_ss;
  integer i;
  integer k;
  wire [11:0] mem_a;
  wire [11:0] mem_b;
  wire [2:0] mem_b_addr;

  // Effective stall disables and global stall enables
  wire ns_stall_disable = nsc_reg[`TFH_G_STALL_DISABLE];
  wire s_stall_disable = sc_reg[`TFH_G_STALL_DISABLE];
  wire ns_gse = nsc_reg[`TFH_G_GSE] & ~ns_stall_disable;
  wire s_gse = sc_reg[`TFH_G_GSE] & ~s_stall_disable;

  // Bus decode
  wire bus_req = avs_read | avs_write;
  wire fire = bus_req & ack_reg;
  wire in_bank = avs_address[7:5] == `TFH_BANK_REGION;
  wire [2:0] bsel = avs_address[4:2];
  wire [1:0] sub = avs_address[1:0];
  wire bank_ok = in_bank & ({29'h0, bsel} < NB);
  wire glob_ok = (avs_address == `TFH_ADDR_NS_CTRL) | (avs_address == `TFH_ADDR_S_CTRL)
    | (avs_address == `TFH_ADDR_GFAULT);
  wire unmapped = ~bank_ok & ~glob_ok;
  wire resume_wr = fire & avs_write & bank_ok & (sub == `TFH_SUB_RESUME);
  wire resume_term = avs_writedata[`TFH_R_TERM];
  wire [2:0] bank1 = req_bank[2:0];
  wire req_impl = ({28'h0, req_bank} < NB);

  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata = rd_mem_reg ? {20'h0, mem_a} : rd_reg;

  // Terminate mode of a bank from its control bits
  function term_mode;
    input [3:0] c;
    input s_dis;
    input ns_dis;
    begin
      term_mode = ~c[`TFH_C_MODE] | (c[`TFH_C_SEC] & (s_dis | (ns_dis & (NS_STALL_DISABLE_SEC != 0))));
    end
  endfunction

  // Check of a bank ahead of translation
  function [1:0] pre_check;
    input [3:0] c;
    input [2:0] f;
    input tm;
    begin
      if (f == `TFH_FSR_RST) begin
        pre_check = A_PASS;
      end else if (c[`TFH_C_HUF]) begin
        pre_check = A_PASS;
      end else if (f[`TFH_F_SS]) begin
        pre_check = A_WAIT;
      end else begin
        pre_check = A_ABORT;
      end
      if (tm && f != `TFH_FSR_RST && f[`TFH_F_SS] && !c[`TFH_C_HUF]) begin
        pre_check = A_WAIT;
      end
    end
  endfunction

  // Abort code chosen from the bank's report enable
  function [1:0] abort_code;
    input [3:0] c;
    begin
      abort_code = c[`TFH_C_FRE] ? `TFH_RSP_ABORT_REP : `TFH_RSP_ABORT_SIL;
    end
  endfunction

  tfh_attr_mem #(
    .WIDTH(12),
    .DEPTH(8),
    .AW(3)
  ) u_attr (
    .sys_clk(sys_clk),
    .wr_en(fire & avs_write & bank_ok & (sub == `TFH_SUB_ATTR)),
    .wr_addr(bsel),
    .wr_data(avs_writedata[11:0]),
    .rda_addr(bsel),
    .rda_data(mem_a),
    .rdb_addr(mem_b_addr),
    .rdb_data(mem_b)
  );

  assign mem_b_addr = (state_reg == S_CHK1) ? mem_b[5:3] : bank1;

  // Any stalled bank and global stall for this request
  always @* begin
    any_ss = 1'b0;
    for (k = 0; k < NB; k = k + 1) begin
      any_ss = any_ss | fsr_reg[k][`TFH_F_SS];
    end
    if (ctl_reg[bank1][`TFH_C_SEC]) begin
      gstall = any_ss & (s_gse | (ns_gse & (NS_GSE_SEC != 0)));
    end else begin
      gstall = any_ss & ns_gse;
    end
  end

  // Request buffer decisions
  always @* begin
    state_next = state_reg;
    code_next = rsp_code;
    gf_set = 6'h00;
    fsr_set_en = 1'b0;
    fsr_set_bank = xlat_s1_bank;
    fsr_set_val = 3'h0;
    act = A_PASS;
    fb = xlat_s1_bank;
    case (state_reg)
      S_START: begin
        if (req_valid) begin
          gf_set[`TFH_GF_USF] = req_stream_miss & nsc_reg[`TFH_G_USF];
          gf_set[`TFH_GF_SMCF] = req_stream_multi & nsc_reg[`TFH_G_SMCF];
          gf_set[`TFH_GF_ICF] = req_map_fault;
          gf_set[`TFH_GF_UCBF] = ~req_impl;
          if (gf_set != 6'h00) begin
            code_next = nsc_reg[`TFH_G_GFRE] ? `TFH_RSP_ABORT_REP : `TFH_RSP_ABORT_SIL;
            state_next = S_RESP;
          end else if (!gstall) begin
            state_next = S_CHK1;
          end
        end
      end
      S_CHK1: begin
        if (mem_b[`TFH_A_TYPE] == `TFH_T_S1FLT || !TYPE_OK[mem_b[`TFH_A_TYPE]]
            || (ctl_reg[xlat_s1_bank][`TFH_C_SEC]
            && mem_b[`TFH_A_TYPE] != `TFH_T_S1BYP)) begin
          gf_set[`TFH_GF_ICF] = 1'b1;
        end else if (mem_b[`TFH_A_TYPE] == `TFH_T_NESTED) begin
          state_next = S_CHK2;
        end else begin
          act = pre_check(ctl_reg[xlat_s1_bank], fsr_reg[xlat_s1_bank],
            term_mode(ctl_reg[xlat_s1_bank], s_stall_disable, ns_stall_disable));
        end
        if (gf_set != 6'h00) begin
          code_next = nsc_reg[`TFH_G_GFRE] ? `TFH_RSP_ABORT_REP : `TFH_RSP_ABORT_SIL;
          state_next = S_RESP;
        end
      end
      S_CHK2: begin
        if (attr1_reg[6] || {29'h0, attr1_reg[5:3]} >= NB) begin
          gf_set[`TFH_GF_ICF] = 1'b1;
        end else if (ctl_reg[xlat_s2_bank][`TFH_C_SEC]
            || mem_b[`TFH_A_TYPE] != `TFH_T_S2ONLY
            || (attr1_reg[`TFH_A_WIDE] && !mem_b[`TFH_A_WIDE])) begin
          gf_set[`TFH_GF_ICF] = 1'b1;
        end else begin
          act = pre_check(ctl_reg[xlat_s1_bank], fsr_reg[xlat_s1_bank],
            term_mode(ctl_reg[xlat_s1_bank], s_stall_disable, ns_stall_disable));
          fb = xlat_s1_bank;
          if (act == A_PASS) begin
            act = pre_check(ctl_reg[xlat_s2_bank], fsr_reg[xlat_s2_bank],
              term_mode(ctl_reg[xlat_s2_bank], s_stall_disable, ns_stall_disable));
            fb = xlat_s2_bank;
          end
        end
        if (gf_set != 6'h00) begin
          code_next = nsc_reg[`TFH_G_GFRE] ? `TFH_RSP_ABORT_REP : `TFH_RSP_ABORT_SIL;
          state_next = S_RESP;
        end
      end
      S_XLAT: begin
        // Stage 2 blame only counts for a nested translation
        fb = (xlat_fault_s2 && xlat_nested) ? xlat_s2_bank : xlat_s1_bank;
        if (xlat_done && !xlat_fault) begin
          code_next = `TFH_RSP_OKAY;
          state_next = S_RESP;
        end else if (xlat_done) begin
          fsr_set_bank = fb;
          gf_set[`TFH_GF_UICF] = ({28'h0, ((xlat_fault_s2 && xlat_nested)
            ? attr2_reg[10:7] : attr1_reg[10:7])} >= NUM_IRQ);
          code_next = abort_code(ctl_reg[fb]);
          state_next = S_RESP;
          if (fsr_reg[fb] != `TFH_FSR_RST) begin
            // Mode is not sampled while a fault stands
            if (fsr_reg[fb][`TFH_F_SS]) begin
              state_next = S_WAIT;
            end else if (ctl_reg[fb][`TFH_C_HUF]) begin
              fsr_set_en = 1'b1;
              fsr_set_val[`TFH_F_MULTI] = 1'b1;
            end
          end else if (term_mode(ctl_reg[fb], s_stall_disable, ns_stall_disable)) begin
            fsr_set_en = 1'b1;
            fsr_set_val[`TFH_F_FAULT] = 1'b1;
          end else begin
            fsr_set_en = 1'b1;
            fsr_set_val[`TFH_F_FAULT] = 1'b1;
            fsr_set_val[`TFH_F_SS] = 1'b1;
            state_next = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (resume_wr && bsel == wait_bank_reg) begin
          if (wait_term_reg && resume_term) begin
            code_next = abort_code(ctl_reg[wait_bank_reg]);
            state_next = S_RESP;
          end else begin
            state_next = S_START;
          end
        end
      end
      S_RESP: begin
        state_next = S_START;
      end
      default: begin
        state_next = S_START;
      end
    endcase
    if ((state_reg == S_CHK1 || state_reg == S_CHK2) && state_next != S_RESP
        && state_next != S_CHK2) begin
      if (act == A_PASS) begin
        state_next = S_XLAT;
      end else if (act == A_WAIT) begin
        state_next = S_WAIT;
      end else begin
        code_next = abort_code(ctl_reg[fb]);
        state_next = S_RESP;
      end
    end
  end

  assign xlat_valid = state_reg == S_XLAT;
  assign rsp_valid = state_reg == S_RESP;
  assign req_ready = state_reg == S_RESP;

  // Request buffer state and captured context
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_START;
      rsp_code <= `TFH_RSP_OKAY;
      xlat_s1_bank <= 3'h0;
      xlat_s2_bank <= 3'h0;
      xlat_nested <= 1'b0;
      attr1_reg <= `TFH_ATTR_RST;
      attr2_reg <= `TFH_ATTR_RST;
      wait_bank_reg <= 3'h0;
      wait_term_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rsp_code <= code_next;
      if (state_reg == S_START) begin
        xlat_s1_bank <= bank1;
        xlat_nested <= 1'b0;
      end
      if (state_reg == S_CHK1) begin
        attr1_reg <= mem_b;
        xlat_s2_bank <= mem_b[5:3];
        xlat_nested <= mem_b[`TFH_A_TYPE] == `TFH_T_NESTED;
      end
      if (state_reg == S_CHK2) begin
        attr2_reg <= mem_b;
      end
      if (state_next == S_WAIT && state_reg != S_WAIT) begin
        wait_bank_reg <= (state_reg == S_XLAT) ? fsr_set_bank : fb;
        wait_term_reg <= (state_reg == S_XLAT) && fsr_set_en;
      end
    end
  end

  // Bus handshake and read data
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rd_mem_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      rd_mem_reg <= bank_ok & (sub == `TFH_SUB_ATTR);
      rd_reg <= 32'h0000_0000;
      if (avs_address == `TFH_ADDR_NS_CTRL) begin
        rd_reg <= {27'h0, nsc_reg[4:1], nsc_reg[`TFH_G_GSE] & ~ns_stall_disable};
      end else if (avs_address == `TFH_ADDR_S_CTRL) begin
        rd_reg <= {30'h0, sc_reg[1], sc_reg[`TFH_G_GSE] & ~s_stall_disable};
      end else if (avs_address == `TFH_ADDR_GFAULT) begin
        rd_reg <= {26'h0, gfs_reg};
      end else if (bank_ok && sub == `TFH_SUB_CTRL) begin
        rd_reg <= {28'h0, ctl_reg[bsel]};
      end else if (bank_ok && sub == `TFH_SUB_STATUS) begin
        rd_reg <= {29'h0, fsr_reg[bsel]};
      end
    end
  end

  // Software registers and fault records; hardware set wins over clear
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nsc_reg <= `TFH_NS_CTRL_RST;
      sc_reg <= `TFH_S_CTRL_RST;
      gfs_reg <= `TFH_GF_RST;
      for (i = 0; i < 8; i = i + 1) begin
        ctl_reg[i] <= `TFH_CTRL_RST;
        fsr_reg[i] <= `TFH_FSR_RST;
      end
    end else begin
      if (fire && avs_write && avs_address == `TFH_ADDR_NS_CTRL) begin
        nsc_reg <= {avs_writedata[4:1], avs_writedata[`TFH_G_GSE]
          & ~avs_writedata[`TFH_G_STALL_DISABLE] & (GSTALL_IMPL != 0)};
      end
      if (fire && avs_write && avs_address == `TFH_ADDR_S_CTRL) begin
        sc_reg <= {avs_writedata[1], avs_writedata[`TFH_G_GSE]
          & ~avs_writedata[`TFH_G_STALL_DISABLE] & (GSTALL_IMPL != 0)};
      end
      gfs_reg <= (gfs_reg & ~((fire && avs_write && avs_address == `TFH_ADDR_GFAULT)
        ? avs_writedata[5:0] : 6'h00)) | gf_set | {fire & unmapped, 5'h00};
      for (i = 0; i < NB; i = i + 1) begin
        if (fire && avs_write && bank_ok && bsel == i && sub == `TFH_SUB_CTRL) begin
          ctl_reg[i] <= avs_writedata[3:0];
        end
        fsr_reg[i] <= (fsr_reg[i]
          & ~((fire && avs_write && bank_ok && bsel == i && sub == `TFH_SUB_STATUS)
            ? avs_writedata[2:0] : 3'h0)
          & ~((resume_wr && bsel == i) ? 3'h4 : 3'h0))
          | ((fsr_set_en && fsr_set_bank == i) ? fsr_set_val : 3'h0);
      end
    end
  end
endmodule // tfh_fault_handler

/* File: verification/tfh_checker_sva.sv */
// Port-level assertions and covers for the fault handler
`timescale 1ns/1ns
`include "tfh_defs.vh"
module tfh_checker #(
  parameter NB = 8,
  parameter GSTALL_IMPL = 1
) (
  input wire sys_clk, // Clock
  input wire rst_b, // Reset
  input wire [7:0] avs_address, // Address
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_writedata, // Write data
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Wait
  input wire req_valid, // Request
  input wire req_ready, // Retired
  input wire [3:0] req_bank, // Bank
  input wire req_stream_miss, // No match
  input wire req_stream_multi, // Many matches
  input wire req_map_fault, // Fault entry
  input wire xlat_valid, // Translate
  input wire [2:0] xlat_s1_bank, // First bank
  input wire [2:0] xlat_s2_bank, // Stage 2 bank
  input wire xlat_nested, // Nested
  input wire xlat_done, // Answer
  input wire xlat_fault, // Failed
  input wire xlat_fault_s2, // Stage 2 failed
  input wire rsp_valid, // Response
  input wire [1:0] rsp_code // Response kind
);
  reg stall_disable_reg; // Last written stall disable
  wire rd_acc = avs_read && !avs_waitrequest; // Read taken
  // Follow the non-secure stall disable
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_disable_reg <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == `TFH_ADDR_NS_CTRL) begin
      stall_disable_reg <= avs_writedata[`TFH_G_STALL_DISABLE];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_wait_once: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
  a_rsp_ready: assert property (rsp_valid |-> req_ready && req_valid)
    else $error("response without retire");
  a_rsp_single: assert property (rsp_valid |=> !rsp_valid) else $error("response too long");
  a_xlat_hold: assert property (xlat_valid && !xlat_done |=> xlat_valid)
    else $error("translation request dropped");
  a_ok_answer: assert property (xlat_valid && xlat_done && !xlat_fault |=>
    rsp_valid && rsp_code == `TFH_RSP_OKAY) else $error("good translation not answered");
  a_fault_abort: assert property (
    xlat_valid && xlat_done && xlat_fault |=> !(rsp_valid && rsp_code == `TFH_RSP_OKAY))
    else $error("failed translation answered okay");
  a_bank_impl: assert property (
    xlat_valid |-> xlat_s1_bank < NB && (!xlat_nested || xlat_s2_bank < NB))
    else $error("absent bank translated");
  a_gse_raz: assert property (
    rd_acc && avs_address == `TFH_ADDR_NS_CTRL && (stall_disable_reg || GSTALL_IMPL == 0)
    |-> !avs_readdata[`TFH_G_GSE]) else $error("global stall enable not zero");
  a_absent_raz: assert property (
    rd_acc && avs_address >= 8'h40 |-> avs_readdata == 32'h0) else $error("absent reg not 0");
  c_fault: cover property (xlat_valid && xlat_done && xlat_fault);
  c_silent: cover property (rsp_valid && rsp_code == `TFH_RSP_ABORT_SIL);
  c_report: cover property (rsp_valid && rsp_code == `TFH_RSP_ABORT_REP);
endmodule // tfh_checker

/* File: verification/tfh_xlat_model.sv */
// Behavioural translation engine answering the fault handler
`timescale 1ns/1ns
module tfh_xlat_model (
  input wire sys_clk, // Clock
  input wire rst_b, // Reset
  input wire xlat_valid, // Translation wanted
  input wire fail_mode, // Answer with failure
  input wire [3:0] lag, // Cycles before answer
  output wire xlat_done, // Answer pulse
  output wire xlat_fault, // Failure, with answer
  output wire xlat_fault_s2 // Stage 2 failure, with answer
);
  reg [3:0] cnt_reg; // Cycles spent waiting
  // Count the cycles of a pending translation
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
    end else if (!xlat_valid || xlat_done) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Answer after the lag; qualifiers toggle outside the answer
  assign xlat_done = xlat_valid && (cnt_reg == lag);
  assign xlat_fault = xlat_done ? fail_mode : cnt_reg[0];
  assign xlat_fault_s2 = xlat_done ? 1'b0 : ~cnt_reg[0];
endmodule // tfh_xlat_model

/* File: verification/tb_translation_fault_handler.sv */
// Self-checking bench for the translation fault handler
`timescale 1ns/1ns
`include "tfh_defs.vh"
module tb_translation_fault_handler;
  localparam NB = 4;
  localparam [1:0] SC = `TFH_SUB_CTRL, SS = `TFH_SUB_STATUS, SR = `TFH_SUB_RESUME;
  localparam [1:0] OK = `TFH_RSP_OKAY, REP = `TFH_RSP_ABORT_REP, SIL = `TFH_RSP_ABORT_SIL;
  localparam [7:0] NSC = `TFH_ADDR_NS_CTRL, GFS = `TFH_ADDR_GFAULT;
  localparam [23:0] GB = {4'h2, 4'h3, 4'h5, 4'h0, 4'h0, 4'h0};
  localparam [17:0] GF = {3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h4};
  localparam [17:0] GX = {3'h0, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0};
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg req_valid = 1'b0;
  reg [3:0] req_bank = 4'h0;
  reg [2:0] req_flt = 3'h0;
  reg fail_mode = 1'b0;
  reg [3:0] lag = 4'h0;
  reg [31:0] rd_val = 32'h0;
  integer errors = 0;
  integer cmp_count = 0;
  integer i;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, req_ready, xlat_valid, xlat_nested, xlat_done, xlat_fault;
  wire xlat_fault_s2, rsp_valid;
  wire [2:0] xlat_s1_bank, xlat_s2_bank;
  wire [1:0] rsp_code;
  // Clock, 8 ns period
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  tfh_fault_handler #(.NB(NB)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
    .req_bank(req_bank), .req_stream_miss(req_flt[0]), .req_stream_multi(req_flt[1]),
    .req_map_fault(req_flt[2]), .xlat_valid(xlat_valid), .xlat_s1_bank(xlat_s1_bank),
    .xlat_s2_bank(xlat_s2_bank), .xlat_nested(xlat_nested), .xlat_done(xlat_done),
    .xlat_fault(xlat_fault), .xlat_fault_s2(xlat_fault_s2), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code));
  tfh_xlat_model xm_u (.sys_clk(sys_clk), .rst_b(rst_b), .xlat_valid(xlat_valid),
    .fail_mode(fail_mode), .lag(lag), .xlat_done(xlat_done), .xlat_fault(xlat_fault),
    .xlat_fault_s2(xlat_fault_s2));
  function [7:0] ba(input [2:0] b, input [1:0] s);
    ba = {`TFH_BANK_REGION, b, s};
  endfunction
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest) @(posedge sys_clk);
      rd_val = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk("readdata", exp, rd_val);
    end
  endtask
  task run(input [3:0] b, input [2:0] f, input [1:0] exp);
    integer n;
    begin
      @(posedge sys_clk);
      req_bank <= b;
      req_flt <= f;
      req_valid <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (!req_ready && n < 300) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
      chk("rsp_code", {30'h0, exp}, (n < 300) ? {30'h0, rsp_code} : 32'hFFFF);
      req_valid <= 1'b0;
    end
  endtask
  task stall_res(input [31:0] term, input [1:0] exp);
    begin
      fork
        run(4'h1, 3'h0, exp);
        begin
          repeat (8) @(posedge sys_clk);
          rdchk(ba(3'h1, SS), 32'h5);
          fail_mode <= 1'b0;
          bus(1'b1, ba(3'h1, SR), term);
        end
      join
    end
  endtask
  task print_verdict;
    begin
      if (errors == 0 && cmp_count > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // Watchdog against a hung wait
  initial begin
    #100000;
    errors = errors + 1;
    print_verdict;
  end
  // Reset, attributes, then the scenarios
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(1'b1, ba(3'h0, `TFH_SUB_ATTR), 32'h401);
    bus(1'b1, ba(3'h1, `TFH_SUB_ATTR), 32'h1);
    bus(1'b1, ba(3'h2, `TFH_SUB_ATTR), 32'h3);
    bus(1'b1, ba(3'h3, `TFH_SUB_ATTR), 32'h2);
    rdchk(NSC, 32'h0);
    rdchk(ba(3'h1, SS), 32'h0);
    bus(1'b1, NSC, 32'h3);
    rdchk(NSC, 32'h2);
    bus(1'b1, NSC, 32'h1);
    rdchk(NSC, 32'h1);
    bus(1'b1, NSC, 32'h0);
    bus(1'b1, 8'hFF, 32'hFFFF);
    rdchk(8'hFF, 32'h0);
    rdchk(GFS, 32'h20);
    bus(1'b1, GFS, 32'h3F);
    // Terminate mode, reporting then silent, then hit-under-fault
    bus(1'b1, ba(3'h0, SC), 32'h4);
    fail_mode <= 1'b1;
    run(4'h0, 3'h0, REP);
    rdchk(ba(3'h0, SS), 32'h1);
    rdchk(GFS, 32'h10);
    fail_mode <= 1'b0;
    run(4'h0, 3'h0, REP);
    bus(1'b1, ba(3'h0, SC), 32'h0);
    run(4'h0, 3'h0, SIL);
    rdchk(ba(3'h0, SS), 32'h1);
    bus(1'b1, ba(3'h0, SC), 32'h2);
    run(4'h0, 3'h0, OK);
    bus(1'b1, ba(3'h0, SC), 32'h3);
    fail_mode <= 1'b1;
    lag <= 4'h2;
    run(4'h0, 3'h0, SIL);
    rdchk(ba(3'h0, SS), 32'h3);
    lag <= 4'h0;
    // Stall mode: terminate by resume, abort after, restart by resume
    bus(1'b1, ba(3'h1, SC), 32'h5);
    fail_mode <= 1'b1;
    stall_res(32'h1, REP);
    rdchk(ba(3'h1, SS), 32'h1);
    run(4'h1, 3'h0, REP);
    bus(1'b1, ba(3'h1, SS), 32'h7);
    bus(1'b1, ba(3'h1, SC), 32'h7);
    fail_mode <= 1'b1;
    stall_res(32'h0, OK);
    bus(1'b1, ba(3'h1, SS), 32'h7);
    bus(1'b1, `TFH_ADDR_S_CTRL, 32'h2);
    bus(1'b1, ba(3'h1, SC), 32'hD);
    fail_mode <= 1'b1;
    run(4'h1, 3'h0, REP);
    rdchk(ba(3'h1, SS), 32'h1);
    fail_mode <= 1'b0;
    // Global fault causes, one per table row
    bus(1'b1, GFS, 32'h3F);
    bus(1'b1, NSC, 32'h1C);
    for (i = 0; i < 6; i = i + 1) begin
      run(GB[i*4 +: 4], GF[i*3 +: 3], REP);
      rdchk(GFS, 32'h1 << GX[i*3 +: 3]);
      bus(1'b1, GFS, 32'h3F);
    end
    bus(1'b1, NSC, 32'h10);
    run(4'h0, 3'h1, OK);
    rdchk(GFS, 32'h0);
    print_verdict;
  end
endmodule // tb_translation_fault_handler
bind tfh_fault_handler tfh_checker #(.NB(NB), .GSTALL_IMPL(GSTALL_IMPL)) chk_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
  .req_bank(req_bank), .req_stream_miss(req_stream_miss), .req_map_fault(req_map_fault),
  .req_stream_multi(req_stream_multi), .xlat_valid(xlat_valid), .xlat_nested(xlat_nested),
  .xlat_s1_bank(xlat_s1_bank), .xlat_s2_bank(xlat_s2_bank), .xlat_done(xlat_done),
  .xlat_fault(xlat_fault), .xlat_fault_s2(xlat_fault_s2), .rsp_valid(rsp_valid),
  .rsp_code(rsp_code));
